// file: luma_config_pkg.sv
// Constants, field layouts and carrier types for the input and luma configuration bank
package luma_config_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_INPUT_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_BRIGHTNESS   = 8'h01;
  localparam logic [7:0] ADDR_CONTRAST     = 8'h02;
  localparam logic [7:0] ADDR_LAST         = 8'h02;

  // Reset values
  localparam logic [7:0] RST_INPUT_FORMAT  = 8'hF8;
  localparam logic [7:0] RST_BRIGHTNESS    = 8'h80;
  localparam logic [7:0] RST_CONTRAST      = 8'hBD;

  // Field positions
  localparam int STD_HI      = 7;
  localparam int STD_LO      = 6;
  localparam int TRAP_BIT    = 5;
  localparam int CLPF_BIT    = 4;
  localparam int AGC_BIT     = 3;
  localparam int MUX_HI      = 2;
  localparam int MUX_LO      = 1;
  localparam int SETUP_BIT   = 7;
  localparam int BRIGHT_HI   = 6;
  localparam int FRAC_BITS   = 7;

  // Black levels and gain figures
  localparam logic [7:0] BLACK_SETUP   = 8'h49;
  localparam logic [7:0] BLACK_PLAIN   = 8'h40;
  localparam logic [7:0] GAIN_UNITY    = 8'h80;
  localparam logic [7:0] GAIN_MAX      = 8'hFF;
  localparam logic [7:0] BURST_TARGET  = 8'h14;
  localparam logic [7:0] LUMA_MAX      = 8'hFF;

  typedef enum logic [1:0] {
    STD_PAL_625  = 2'b00,
    STD_PAL_M    = 2'b01,
    STD_PAL_N_SP = 2'b10,
    STD_NTSC_M   = 2'b11
  } videoStd_t;

  typedef enum logic [1:0] {
    MUX_CVBS0 = 2'b00,
    MUX_CVBS1 = 2'b01,
    MUX_CVBS2 = 2'b10,
    MUX_SVIDEO = 2'b11
  } inputMux_t;

  // Decoded configuration carried to the decoder core
  typedef struct packed {
    videoStd_t  standard;
    logic       trapBypass;
    logic       chromaLpfBypass;
    logic       chromaAgcOn;
    logic [1:0] compositeSel;
    logic       sVideoMode;
    logic       setupCancel;
  } videoCfg_t;

endpackage : luma_config_pkg

// file: luma_config_bank.sv
// Input format, brightness and contrast registers with the luma and chroma gain paths they steer
`timescale 1ns/100ps
`default_nettype none
module luma_config_bank
(
  input  wire logic                      clock,        // 250 MHz clock
  input  wire logic                      srst,         // Synchronous reset, active high
  input  wire logic                      ptrLoad,      // Pulse: load register pointer
  input  wire logic [7:0]                ptrData,      // New pointer value
  input  wire logic                      wrStrobe,     // Pulse: write one byte at pointer
  input  wire logic [7:0]                wrData,       // Byte to write
  input  wire logic                      rdStrobe,     // Pulse: read one byte at pointer
  output logic [7:0]                     rdData,       // Byte read, held until next read
  output logic [7:0]                     regPtr,       // Current register pointer
  output luma_config_pkg::videoCfg_t     cfg,          // Decoded configuration
  input  wire logic                      lumaInValid,  // Luma sample valid
  input  wire logic [7:0]                lumaIn,       // Raw luma sample
  output logic                           lumaOutValid, // Processed luma valid
  output logic [7:0]                     lumaOut,      // Processed, clamped luma
  input  wire logic                      burstValid,   // Pulse: new burst amplitude
  input  wire logic [7:0]                burstAmp,     // Measured burst amplitude in IRE
  output logic [7:0]                     chromaGain    // Chroma gain, 1.7 format
);

  // Register bank and byte port state
  logic [7:0]  formatReg_q;
  logic [7:0]  brightReg_q;
  logic [7:0]  contrastReg_q;
  logic        sVideoMode_q;
  logic [7:0]  regPtr_q;
  logic [7:0]  rdData_q;
  logic [7:0]  regPtr_d;
  logic        wrHit;
  logic        rdHit;
  logic        fmtWrite;

  // Luma and chroma datapath
  logic [7:0]  blackLevel;
  logic signed [10:0] brightOffset;
  logic signed [10:0] offsetSum_q;
  logic        stage1Valid_q;
  logic signed [19:0] product;
  logic [7:0]  lumaOut_d;
  logic [7:0]  lumaOut_q;
  logic        lumaOutValid_q;
  logic [7:0]  chromaGain_d;
  logic [7:0]  chromaGain_q;

  // Pointer step with wrap after the last register
  function automatic logic [7:0] nextPtr(input logic [7:0] ptr);
    nextPtr = (ptr >= luma_config_pkg::ADDR_LAST) ? 8'h00 : ptr + 8'h01;
  endfunction

  // Register contents at an address, unused bits as zero
  function automatic logic [7:0] readReg(input logic [7:0] addr, input logic [7:0] fmt,
                                         input logic [7:0] bri, input logic [7:0] con);
    case (addr)
      luma_config_pkg::ADDR_INPUT_FORMAT: readReg = {fmt[7:1], 1'b0};
      luma_config_pkg::ADDR_BRIGHTNESS:   readReg = bri;
      luma_config_pkg::ADDR_CONTRAST:     readReg = con;
      default:                            readReg = 8'h00;
    endcase
  endfunction

  // Write has priority over a read in the same cycle
  assign wrHit = wrStrobe && !ptrLoad;
  assign rdHit = rdStrobe && !ptrLoad && !wrStrobe;

  // Write aimed at the input format register
  assign fmtWrite = wrHit && (regPtr_q == luma_config_pkg::ADDR_INPUT_FORMAT);

  // Pointer next value
  always_comb
  begin
    if (ptrLoad)
      regPtr_d = ptrData;
    else if (wrHit || rdHit)
      regPtr_d = nextPtr(regPtr_q);
    else
      regPtr_d = regPtr_q;
  end

  // Register pointer
  always_ff @(posedge clock)
  begin
    if (srst)
      regPtr_q <= 8'h00;
    else
      regPtr_q <= regPtr_d;
  end

  // Register writes
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      formatReg_q   <= luma_config_pkg::RST_INPUT_FORMAT;
      brightReg_q   <= luma_config_pkg::RST_BRIGHTNESS;
      contrastReg_q <= luma_config_pkg::RST_CONTRAST;
    end
    else if (wrHit)
    begin
      case (regPtr_q)
        luma_config_pkg::ADDR_INPUT_FORMAT: formatReg_q <= {wrData[7:1], 1'b0};
        luma_config_pkg::ADDR_BRIGHTNESS:   brightReg_q <= wrData;
        luma_config_pkg::ADDR_CONTRAST:     contrastReg_q <= wrData;
        default: ;
      endcase
    end
  end

  // S-Video flag kept in its own flop so the carrier output stays registered
  always_ff @(posedge clock)
  begin
    if (srst)
      sVideoMode_q <= (luma_config_pkg::RST_INPUT_FORMAT[luma_config_pkg::MUX_HI:luma_config_pkg::MUX_LO] == 2'b11);
    else if (fmtWrite)
      sVideoMode_q <= (wrData[luma_config_pkg::MUX_HI:luma_config_pkg::MUX_LO] == 2'b11);
  end

  // Read data capture
  always_ff @(posedge clock)
  begin
    if (srst)
      rdData_q <= 8'h00;
    else if (rdHit)
      rdData_q <= readReg(regPtr_q, formatReg_q, brightReg_q, contrastReg_q);
  end

  // Field decode into the configuration carrier
  always_comb
  begin
    cfg.standard        = luma_config_pkg::videoStd_t'(
                            formatReg_q[luma_config_pkg::STD_HI:luma_config_pkg::STD_LO]);
    cfg.trapBypass      = formatReg_q[luma_config_pkg::TRAP_BIT];
    cfg.chromaLpfBypass = formatReg_q[luma_config_pkg::CLPF_BIT];
    cfg.chromaAgcOn     = formatReg_q[luma_config_pkg::AGC_BIT];
    cfg.compositeSel    = {formatReg_q[luma_config_pkg::MUX_LO], formatReg_q[luma_config_pkg::MUX_HI]};
    cfg.sVideoMode      = sVideoMode_q;
    cfg.setupCancel     = brightReg_q[luma_config_pkg::SETUP_BIT];
  end

  // Black level and sign-extended brightness offset
  assign blackLevel   = brightReg_q[luma_config_pkg::SETUP_BIT] ? luma_config_pkg::BLACK_SETUP
                                                                : luma_config_pkg::BLACK_PLAIN;
  assign brightOffset = $signed({{4{brightReg_q[luma_config_pkg::BRIGHT_HI]}},
                                 brightReg_q[luma_config_pkg::BRIGHT_HI:0]});

  // Stage 1: black level removed, brightness added
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      offsetSum_q   <= 11'sh000;
      stage1Valid_q <= 1'b0;
    end
    else
    begin
      stage1Valid_q <= lumaInValid;
      offsetSum_q   <= $signed({3'h0, lumaIn})
                     - $signed({3'h0, blackLevel})
                     + brightOffset;
    end
  end

  // Contrast gain on the offset result
  assign product = offsetSum_q * $signed({1'b0, contrastReg_q});

  // Scaled product clamped to eight bits, never wrapping
  always_comb
  begin
    if (product < 20'sh00000)
      lumaOut_d = 8'h00;
    else if (product[19:luma_config_pkg::FRAC_BITS] > 13'(luma_config_pkg::LUMA_MAX))
      lumaOut_d = luma_config_pkg::LUMA_MAX;
    else
      lumaOut_d = product[luma_config_pkg::FRAC_BITS +: 8];
  end

  // Stage 2: clamped luma registered
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      lumaOut_q      <= 8'h00;
      lumaOutValid_q <= 1'b0;
    end
    else
    begin
      lumaOutValid_q <= stage1Valid_q;
      lumaOut_q      <= lumaOut_d;
    end
  end

  // Chroma gain next value: unity when off, one saturating step per burst pulse when on, none when burstAmp equals BURST_TARGET
  always_comb
  begin
    chromaGain_d = chromaGain_q;
    if (!formatReg_q[luma_config_pkg::AGC_BIT])
      chromaGain_d = luma_config_pkg::GAIN_UNITY;
    else if (burstValid)
    begin
      if (burstAmp < luma_config_pkg::BURST_TARGET && chromaGain_q != luma_config_pkg::GAIN_MAX)
        chromaGain_d = chromaGain_q + 8'h01;
      else if (burstAmp > luma_config_pkg::BURST_TARGET && chromaGain_q != 8'h00)
        chromaGain_d = chromaGain_q - 8'h01;
    end
  end

  // Chroma gain register
  always_ff @(posedge clock)
  begin
    if (srst)
      chromaGain_q <= luma_config_pkg::GAIN_UNITY;
    else
      chromaGain_q <= chromaGain_d;
  end

  // Outputs straight from their flops
  assign rdData       = rdData_q;
  assign regPtr       = regPtr_q;
  assign lumaOut      = lumaOut_q;
  assign lumaOutValid = lumaOutValid_q;
  assign chromaGain   = chromaGain_q;

endmodule // luma_config_bank
`default_nettype wire

// file: luma_config_bank_properties.sv
// Port assertions for the configuration bank
`timescale 1ns/100ps
`default_nettype none
module luma_config_bank_properties
(
  input wire logic                       clock, // Clock
  input wire logic                       srst, // Reset
  input wire logic                       ptrLoad, // Load
  input wire logic [7:0]                 ptrData, // Pointer in
  input wire logic                       wrStrobe, // Write
  input wire logic                       rdStrobe, // Read
  input wire logic [7:0]                 rdData, // Read byte
  input wire logic [7:0]                 regPtr, // Pointer
  input wire luma_config_pkg::videoCfg_t cfg, // Config
  input wire logic                       lumaInValid, // Luma in
  input wire logic                       lumaOutValid, // Luma out
  input wire logic                       burstValid, // Burst
  input wire logic [7:0]                 burstAmp, // Amplitude
  input wire logic [7:0]                 chromaGain // Gain
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_ptr_load:
    assert property (ptrLoad |=> regPtr == $past(ptrData)) else $error("pointer load");
  a_ptr_step:
    assert property ((wrStrobe || rdStrobe) && !ptrLoad |=> regPtr == ($past(regPtr) > 8'h01 ? 8'h00
      : $past(regPtr) + 8'h01)) else $error("pointer step");
  a_bit0_zero:
    assert property (rdStrobe && !ptrLoad && !wrStrobe && regPtr == 8'h00 |=> !rdData[0]) else $error("bit 0 set");
  a_luma_delay:
    assert property (##2 (lumaOutValid == $past(lumaInValid, 2))) else $error("luma valid delay");
  a_agc_unity:
    assert property (!cfg.chromaAgcOn |=> chromaGain == 8'h80) else $error("gain not unity");
  a_agc_up:
    assert property (cfg.chromaAgcOn && burstValid && burstAmp < 8'h14 && chromaGain != 8'hFF
      |=> chromaGain == $past(chromaGain) + 8'h01) else $error("gain not raised");
  a_agc_down:
    assert property (cfg.chromaAgcOn && burstValid && burstAmp > 8'h14 && chromaGain != 8'h00
      |=> chromaGain == $past(chromaGain) - 8'h01) else $error("gain not lowered");
  a_rst_defaults:
    assert property ($fell(srst) |-> regPtr == 8'h00 && chromaGain == 8'h80 && cfg.setupCancel
      && cfg.standard == luma_config_pkg::STD_NTSC_M) else $error("reset values");
endmodule // luma_config_bank_properties

bind luma_config_bank luma_config_bank_properties i_props (.clock, .srst, .ptrLoad, .ptrData, .wrStrobe,
  .rdStrobe, .rdData, .regPtr, .cfg, .lumaInValid, .lumaOutValid, .burstValid, .burstAmp, .chromaGain);
`default_nettype wire

// file: host_port_model.sv
// Host model driving the register byte port
`timescale 1ns/100ps
`default_nettype none
module host_port_model
(
  input  wire logic  clock, // Clock
  output logic       ptrLoad, // Pointer load
  output logic [7:0] ptrData, // Pointer value
  output logic       wrStrobe, // Write pulse
  output logic [7:0] wrData, // Write byte
  output logic       rdStrobe // Read pulse
);
  // Idle at time zero
  initial
  begin
    {ptrLoad, wrStrobe, rdStrobe} = 3'h0;
    {ptrData, wrData} = 16'h0000;
  end

  // One request per edge; unused data lines carry inverted junk
  task automatic op(input logic [2:0] kind, input logic [7:0] d);
    @(posedge clock);
    {ptrLoad, wrStrobe, rdStrobe} <= kind;
    ptrData <= kind[2] ? d : ~d;
    wrData  <= kind[1] ? d : ~d;
  endtask
endmodule // host_port_model
`default_nettype wire

// file: luma_config_bank_bench.sv
// Random and corner stimulus bench for the configuration bank
`timescale 1ns/100ps
`default_nettype none
module luma_config_bank_bench;
  logic                       clock = 1'b0;
  logic                       srst = 1'b1;
  logic                       lumaInValid = 1'b0;
  logic                       burstValid = 1'b0;
  logic [7:0]                 lumaIn = 8'h00;
  logic [7:0]                 burstAmp = 8'h00;
  logic                       ptrLoad, wrStrobe, rdStrobe, lumaOutValid;
  logic [7:0]                 ptrData, wrData, rdData, regPtr, lumaOut, chromaGain, r0, r1, r2, g;
  luma_config_pkg::videoCfg_t cfg;
  logic [8:0]                 q[$];
  int                         fail_count = 0;
  int                         n_compared = 0;

  // Clock and design
  always #2 clock = ~clock;
  host_port_model i_host_port_model (.clock, .ptrLoad, .ptrData, .wrStrobe, .wrData, .rdStrobe);
  luma_config_bank i_luma_config_bank (.clock, .srst, .ptrLoad, .ptrData, .wrStrobe, .wrData, .rdStrobe, .rdData,
    .regPtr, .cfg, .lumaInValid, .lumaIn, .lumaOutValid, .lumaOut, .burstValid, .burstAmp, .chromaGain);

  // Expected values
  function automatic logic [7:0] luma_exp(input logic [7:0] y, input logic [7:0] b, input logic [7:0] c);
    int v;
    v = (int'(y) - int'(b[7] ? 8'h49 : 8'h40) + int'(signed'(b[6:0]))) * int'(c) >>> 7;
    return v < 0 ? 8'h00 : |v[31:8] ? 8'hFF : v[7:0];
  endfunction
  function automatic logic [8:0] cfg_exp(input logic [7:0] a, input logic [7:0] b);
    return {a[7:3], a[1], a[2], a[2:1] == 2'h3, b[7]};
  endfunction

  // Compare, verdict and host shorthand
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [2:0] k, input logic [7:0] d);
    i_host_port_model.op(k, d);
  endtask

  // Four back-to-back reads from pointer 0, crossing the wrap
  task automatic read_all();
    op(3'h4, 8'h00);
    op(3'h1, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      op(k < 3 ? 3'h1 : 3'h0, 8'h00);
      #1 check({1'b0, rdData}, {1'b0, k == 1 ? r1 : k == 2 ? r2 : r0 & 8'hFE});
    end
    check(cfg, cfg_exp(r0, r1));
  endtask

  // Luma stream with random gaps, checked two cycles on
  task automatic luma_run();
    logic [7:0] y;
    logic       v;
    q = {};
    repeat (24)
    begin
      y = $urandom % 4 == 0 ? {8{$urandom % 2 == 1}} : 8'($urandom);
      v = 1'($urandom);
      @(posedge clock);
      lumaInValid <= v;
      lumaIn      <= y;
      q.push_back({v, v ? luma_exp(y, r1, r2) : 8'h00});
      #1;
      if (q.size() == 3)
        check({lumaOutValid, lumaOutValid ? lumaOut : 8'h00}, q.pop_front());
    end
  endtask

  // Write all three registers back to back, then read and stream
  task automatic write_all(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    {r0, r1, r2} = {a, b, c};
    op(3'h4, 8'h00);
    op(3'h2, a);
    op(3'h2, b);
    op(3'h2, c);
    read_all();
    if (!r0[3])
      check({1'b0, chromaGain}, 9'h080);
    luma_run();
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(24301));
    {r0, r1, r2} = 24'hF880BD;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    read_all();
    g = 8'h80;
    repeat (30)
    begin
      @(posedge clock);
      burstValid <= 1'b1;
      burstAmp   <= $urandom % 3 == 0 ? 8'h14 : 8'($urandom % 41);
      @(posedge clock);
      burstValid <= 1'b0;
      g = burstAmp < 8'h14 ? g + 8'h01 : burstAmp > 8'h14 ? g - 8'h01 : g;
      #1 check({1'b0, chromaGain}, {1'b0, g});
    end
    op(3'h4, 8'h03);
    op(3'h2, 8'hAA);
    op(3'h4, 8'h04);
    op(3'h1, 8'h00);
    op(3'h0, 8'h00);
    #1 check({rdData, regPtr[0]}, 9'h000);
    read_all();
    write_all(8'h0F, 8'h3F, 8'hFF);
    write_all(8'h43, 8'hC0, 8'h00);
    repeat (12)
    begin
      r0 = 8'($urandom);
      r0[5:4] = r0[7:6] == 2'h3 ? r0[5:4] : 2'h0;
      write_all(r0, 8'($urandom), 8'($urandom));
    end
    // Second reset in mid-run: pointer, gain and registers back to defaults
    @(posedge clock);
    srst        <= 1'b1;
    lumaInValid <= 1'b0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    {r0, r1, r2} = 24'hF880BD;
    #1 check({1'b0, regPtr}, 9'h000);
    check({1'b0, chromaGain}, 9'h080);
    read_all();
    wrap_up();
  end

  // Watchdog
  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule // luma_config_bank_bench
`default_nettype wire
